// ==== rtl/pfs_top.sv ====
// Purpose: Feedback divider control and status pin selector
// Assumes: Pins are event inputs far slower than sys_clk_i
// Notes:   APB slave, zero wait states, index times four addressing
// Notes on behaviour
// - Bypass forces B to one in fixed mode
// - Prescaler codes pick fixed or dual modulus
// - Code 110 divides 32/33, 32 when A zero
// - Code 000001 gives delayed N output
// - Codes 000010-000110 give R, A, prescaler, pump
// - Other leading-zero codes drive ground
// - 100000 ground, 100001 first reference clock
// - 100010 second reference, none when differential
// - 100011 reference selected into loop
// - 100100 unselected reference, none when differential
// - 100101 selected reference valid, active high
// - 100110 unselected reference status, active high
// - 100111, 101000 reference frequency status levels
// - 101001 AND of both frequency levels
// - 101010 lock, selected status, oscillator AND
// - 101011 oscillator frequency status level
// - 101100 reference in use, high second
// - 101101 digital lock flag, active high
// - 101110 holdover active, active high
// - 101111 lock pin comparator output
// - Leading 11 codes invert status levels
`timescale 1ns/1ps
module pfs_top
  import pfs_pkg::*;
(
  input  wire logic          sys_clk_i,
  input  wire logic          rst_i,
  input  wire pfs_apb_req_t  apb_i,
  output logic               pready_o,
  output logic        [31:0] prdata_o,
  output logic               pslverr_o,
  input  wire logic   [1:0]  ref_pin_i,
  input  wire logic          vco_pin_i,
  input  wire pfs_mon_t      mon_i,
  output logic               status_o,
  output logic               fbk_div_o,
  output logic               ref_div_o,
  output logic               pump_up_o,
  output logic               pump_dn_o
);

  // Register state
  logic [7:0]  fbk_q;
  logic [7:0]  sts_q;
  logic [13:0] rdiv_q;
  logic [5:0]  acnt_q;
  logic [12:0] bcnt_q;
  logic [31:0] prdata_q;

  // APB decode
  wire pfs_idx_t idx     = apb_i.paddr[7:2];
  wire           aligned = (apb_i.paddr[1:0] == 2'b00);
  wire           hit_fbk = aligned && (idx == PFS_IDX_FBK);
  wire           hit_sts = aligned && (idx == PFS_IDX_STS);
  wire           hit_rdv = aligned && (idx == PFS_IDX_RDIV);
  wire           hit_acn = aligned && (idx == PFS_IDX_ACNT);
  wire           hit_bcn = aligned && (idx == PFS_IDX_BCNT);
  wire           hit_mon = aligned && (idx == PFS_IDX_MON);
  wire           mapped  = hit_fbk | hit_sts | hit_rdv |
                           hit_acn | hit_bcn | hit_mon;
  wire           access  = apb_i.psel & apb_i.penable;
  wire           setup   = apb_i.psel & ~apb_i.penable;
  wire           wr_en   = access & apb_i.pwrite & mapped;

  assign pready_o  = access;
  assign pslverr_o = access & ~mapped;
  assign prdata_o  = prdata_q;

  // Control fields
  wire      rst_all = fbk_q[PFS_FBK_RST_ALL];
  wire      ab_clr  = fbk_q[PFS_FBK_RST_AB] | rst_all;
  wire      r_clr   = fbk_q[PFS_FBK_RST_R] | rst_all;
  wire      byp     = fbk_q[PFS_FBK_BYP];
  wire pfs_pre_t pre_mode =
    pfs_pre_t'(fbk_q[PFS_FBK_PRE_LSB +: PFS_FBK_PRE_W]);
  wire [5:0] sel    = sts_q[PFS_STS_SEL_LSB +: PFS_STS_SEL_W];

  // Pin sampling
  logic [2:0] pin_lvl;
  logic       vco_prev_q;
  logic       ref_prev_q;

  pfs_sync #(
    .W (3)
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .pin_i     ({vco_pin_i, ref_pin_i}),
    .lvl_o     (pin_lvl)
  );

  wire first_lvl  = pin_lvl[0];
  wire second_lvl = pin_lvl[1];
  wire vco_lvl    = pin_lvl[2];
  wire diff       = mon_i.diff_mode;

  // Differential input arrives on the first pin pair
  wire sel_clk   = (!diff && mon_i.ref_sel) ? second_lvl
                                            : first_lvl;
  wire unsel_clk = diff ? 1'b0 :
                   (mon_i.ref_sel ? first_lvl : second_lvl);
  wire vco_tick  = vco_lvl & ~vco_prev_q;
  wire ref_tick  = sel_clk & ~ref_prev_q;

  // Prescaler
  wire pre_fixed = (pre_mode == PRE_DIV1) ||
                   (pre_mode == PRE_DIV2) ||
                   (pre_mode == PRE_DIV3);
  wire pre_dual  = ~pre_fixed;
  wire [2:0] pre_code = fbk_q[PFS_FBK_PRE_LSB +: PFS_FBK_PRE_W];

  // Lower ratio is a power of two except the divide-by-3 code
  wire [5:0] pre_base =
    (pre_mode == PRE_DIV3) ? PFS_DIV3_VAL :
    pre_dual ? 6'(6'h01 << (pre_code - 3'h1)) :
               6'(6'h01 << pre_code);

  logic [5:0] pre_cnt_q;
  logic [5:0] a_cnt_q;
  logic       a_out_q;
  logic       pre_out_q;

  // Less-than: A zero, or a leftover count, keeps lower ratio
  wire       a_act    = (a_cnt_q < acnt_q);
  wire [5:0] modulus  = pre_base +
                        {5'h00, pre_dual & a_act};
  wire       pre_last = (pre_cnt_q >= modulus - 6'h01);
  wire       pre_tick = vco_tick & pre_last & ~ab_clr;
  wire       a_wrap   = pre_tick & pre_dual & a_act &
                        (a_cnt_q == acnt_q - 6'h01);

  // Bypass honoured only in fixed mode; dual mode keeps B
  wire       byp_act  = byp & pre_fixed;
  wire [13:0] b_eff   = byp_act ? PFS_DIV_ONE
                                : {1'b0, bcnt_q};

  logic n_wrap;
  logic n_pls;
  logic r_pls;

  pfs_div u_ndiv (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .clr_i     (ab_clr),
    .tick_i    (pre_tick),
    .div_i     (b_eff),
    .wrap_o    (n_wrap),
    .pulse_o   (n_pls)
  );

  pfs_div u_rdiv (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .clr_i     (r_clr),
    .tick_i    (ref_tick),
    .div_i     (rdiv_q),
    .wrap_o    (),
    .pulse_o   (r_pls)
  );

  // Delay stage and phase detector
  logic n_dly_q;
  logic r_dly_q;
  logic up_q;
  logic dn_q;

  wire up_set  = up_q | r_dly_q;
  wire dn_set  = dn_q | n_dly_q;
  wire pd_both = up_set & dn_set;
  wire up_d    = up_set & ~pd_both;
  wire dn_d    = dn_set & ~pd_both;

  // Status sources
  logic [7:0]  int_vec;
  logic [15:0] mon_vec;
  logic        status_q;

  assign int_vec[IS_GND]  = 1'b0;
  assign int_vec[IS_NDIV] = n_dly_q;
  assign int_vec[IS_RDIV] = r_dly_q;
  assign int_vec[IS_ADIV] = a_out_q;
  assign int_vec[IS_PRE]  = pre_out_q;
  assign int_vec[IS_UP]   = up_q;
  assign int_vec[IS_DN]   = dn_q;
  assign int_vec[IS_NONE] = 1'b0;

  assign mon_vec[MS_GND]        = 1'b0;
  assign mon_vec[MS_FIRST]      = first_lvl;
  assign mon_vec[MS_SECOND]     = second_lvl & ~diff;
  assign mon_vec[MS_SEL]        = sel_clk;
  assign mon_vec[MS_UNSEL]      = unsel_clk;
  assign mon_vec[MS_SEL_OK]     = mon_i.sel_ok;
  assign mon_vec[MS_UNSEL_OK]   = mon_i.unsel_ok & ~diff;
  assign mon_vec[MS_FIRST_FRQ]  = mon_i.first_frq_ok;
  assign mon_vec[MS_SECOND_FRQ] = mon_i.second_frq_ok;
  assign mon_vec[MS_BOTH_FRQ]   = mon_i.first_frq_ok &
                                  mon_i.second_frq_ok;
  assign mon_vec[MS_LOCK_ALL]   = mon_i.digital_lock_flag &
                                  mon_i.sel_ok &
                                  mon_i.vco_ok;
  assign mon_vec[MS_VCO_OK]     = mon_i.vco_ok;
  assign mon_vec[MS_WHICH]      = mon_i.ref_sel & ~diff;
  assign mon_vec[MS_LOCK]       = mon_i.digital_lock_flag;
  assign mon_vec[MS_HOLD]       = mon_i.holdover;
  assign mon_vec[MS_LDCMP]      = mon_i.lock_cmp;

  // Leading zero: only codes 000001-000110 carry a source
  wire int_pick = (sel[4:3] == 2'b00) ? int_vec[sel[2:0]]
                                      : 1'b0;
  wire mon_pick = mon_vec[sel[3:0]];
  wire mon_dyn  = (sel[3:0] >= MS_FIRST) &&
                  (sel[3:0] <= MS_UNSEL);
  // Clocks pass unchanged; levels, ground too, invert
  wire mon_inv  = sel[4] & ~mon_dyn;
  wire status_d = sel[5] ? (mon_pick ^ mon_inv)
                         : int_pick;

  assign status_o  = status_q;
  assign fbk_div_o = n_dly_q;
  assign ref_div_o = r_dly_q;
  assign pump_up_o = up_q;
  assign pump_dn_o = dn_q;

  // Read data captured in setup, stable through access
  wire [31:0] rd_mux =
    hit_fbk ? {24'h000000, fbk_q} :
    hit_sts ? {24'h000000, sts_q} :
    hit_rdv ? {18'h00000, rdiv_q} :
    hit_acn ? {26'h0000000, acnt_q} :
    hit_bcn ? {19'h00000, bcnt_q} :
    hit_mon ? {25'h0000000, byp_act, pre_fixed, a_act,
               dn_q, up_q, status_q, n_dly_q} :
    32'h00000000;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      fbk_q  <= PFS_FBK_RST;
      sts_q  <= PFS_STS_RST;
      rdiv_q <= PFS_RDIV_RST;
      acnt_q <= PFS_ACNT_RST;
      bcnt_q <= PFS_BCNT_RST;
    end else if (wr_en) begin
      if (hit_fbk) fbk_q  <= apb_i.pwdata[7:0];
      if (hit_sts) sts_q  <= apb_i.pwdata[7:0];
      if (hit_rdv) rdiv_q <= apb_i.pwdata[13:0];
      if (hit_acn) acnt_q <= apb_i.pwdata[5:0];
      if (hit_bcn) bcnt_q <= apb_i.pwdata[12:0];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      prdata_q <= '0;
    end else if (setup) begin
      prdata_q <= rd_mux;
    end
  end

  // Prescaler and A counter; a new N cycle restarts A
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || ab_clr) begin
      pre_cnt_q <= '0;
      a_cnt_q   <= '0;
      a_out_q   <= 1'b0;
      pre_out_q <= 1'b0;
    end else begin
      a_out_q   <= a_wrap;
      pre_out_q <= pre_tick;
      if (vco_tick) begin
        pre_cnt_q <= pre_last ? '0 : pre_cnt_q + 6'h01;
      end
      if (n_wrap) begin
        a_cnt_q <= '0;
      end else if (pre_tick && pre_dual && a_act) begin
        a_cnt_q <= a_cnt_q + 6'h01;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      vco_prev_q <= 1'b0;
      ref_prev_q <= 1'b0;
      n_dly_q    <= 1'b0;
      r_dly_q    <= 1'b0;
      up_q       <= 1'b0;
      dn_q       <= 1'b0;
      status_q   <= 1'b0;
    end else begin
      vco_prev_q <= vco_lvl;
      ref_prev_q <= sel_clk;
      n_dly_q    <= n_pls;
      r_dly_q    <= r_pls;
      up_q       <= up_d;
      dn_q       <= dn_d;
      status_q   <= status_d;
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  a_reset_all_holds: assert property (
    rst_all ##1 rst_all |-> !n_pls && !r_pls && pre_cnt_q == 6'h00)
    else $error("counters run while reset-all is set");

  a_bypass_div_one: assert property (
    pre_tick && byp_act |=> n_pls)
    else $error("bypass did not give N every prescaler tick");

  a_fixed_div_one: assert property (
    vco_tick && !ab_clr && pre_mode == PRE_DIV1 |-> pre_tick)
    else $error("divide-by-one prescaler missed a tick");

  a_dm32_lower: assert property (
    pre_mode == PRE_DM32 && acnt_q == 6'h00 |-> modulus == 6'd32)
    else $error("dual 32/33 not at 32 with A zero");

  a_mux_ndiv: assert property (
    sel == 6'b000001 |=> status_q == $past(n_dly_q))
    else $error("status pin not following N output");

  a_mux_pump_up: assert property (
    sel == 6'b000101 |=> status_q == $past(up_q))
    else $error("status pin not following pump up");

  a_mux_ground: assert property (
    !sel[5] && sel[4:0] > 5'h06 |=> !status_q)
    else $error("unassigned low code not grounded");

  a_mux_lock_all: assert property (
    sel == 6'b101010 |=> status_q == $past(mon_i.digital_lock_flag
      && mon_i.sel_ok && mon_i.vco_ok))
    else $error("lock AND level wrong on status pin");

  a_mux_holdover: assert property (
    sel == 6'b101110 |=> status_q == $past(mon_i.holdover))
    else $error("holdover level wrong on status pin");

  a_mux_inverted: assert property (
    sel == 6'b111101 |=> status_q != $past(mon_i.digital_lock_flag))
    else $error("inverted lock level not inverted");

  a_second_diff: assert property (
    sel == 6'b100010 && diff |=> !status_q)
    else $error("second reference shown in differential mode");

endmodule

// ==== rtl/pfs_pkg.sv ====
// Purpose: Shared constants and types for the feedback divider block
// Assumes: APB data 32 bits; register index times four is the address
// Notes:   Sources for the status pin are indices into level vectors
package pfs_pkg;

  localparam int PFS_IDX_W = 6;
  typedef logic [PFS_IDX_W-1:0] pfs_idx_t;

  localparam pfs_idx_t PFS_IDX_STS  = 6'h07;
  localparam pfs_idx_t PFS_IDX_RDIV = 6'h11;
  localparam pfs_idx_t PFS_IDX_ACNT = 6'h13;
  localparam pfs_idx_t PFS_IDX_BCNT = 6'h14;
  localparam pfs_idx_t PFS_IDX_FBK  = 6'h16;
  localparam pfs_idx_t PFS_IDX_MON  = 6'h1f;

  localparam int PFS_FBK_RST_R   = 6;
  localparam int PFS_FBK_RST_AB  = 5;
  localparam int PFS_FBK_RST_ALL = 4;
  localparam int PFS_FBK_BYP     = 3;
  localparam int PFS_FBK_PRE_LSB = 0;
  localparam int PFS_FBK_PRE_W   = 3;
  localparam int PFS_STS_SEL_LSB = 2;
  localparam int PFS_STS_SEL_W   = 6;

  localparam logic [7:0]  PFS_FBK_RST  = 8'h00;
  localparam logic [7:0]  PFS_STS_RST  = 8'h00;
  localparam logic [13:0] PFS_RDIV_RST = 14'h0001;
  localparam logic [5:0]  PFS_ACNT_RST = 6'h00;
  localparam logic [12:0] PFS_BCNT_RST = 13'h0001;
  localparam logic [13:0] PFS_DIV_ONE  = 14'h0001;
  localparam logic [5:0]  PFS_DIV3_VAL = 6'h03;

  typedef enum logic [2:0] {
    PRE_DIV1 = 3'b000, PRE_DIV2 = 3'b001,
    PRE_DM2  = 3'b010, PRE_DM4  = 3'b011,
    PRE_DM8  = 3'b100, PRE_DM16 = 3'b101,
    PRE_DM32 = 3'b110, PRE_DIV3 = 3'b111
  } pfs_pre_t;

  typedef enum logic [2:0] {
    IS_GND = 3'b000, IS_NDIV = 3'b001, IS_RDIV = 3'b010,
    IS_ADIV = 3'b011, IS_PRE = 3'b100, IS_UP = 3'b101,
    IS_DN = 3'b110, IS_NONE = 3'b111
  } pfs_int_sel_t;

  typedef enum logic [3:0] {
    MS_GND = 4'h0, MS_FIRST = 4'h1, MS_SECOND = 4'h2,
    MS_SEL = 4'h3, MS_UNSEL = 4'h4, MS_SEL_OK = 4'h5,
    MS_UNSEL_OK = 4'h6, MS_FIRST_FRQ = 4'h7,
    MS_SECOND_FRQ = 4'h8, MS_BOTH_FRQ = 4'h9,
    MS_LOCK_ALL = 4'ha, MS_VCO_OK = 4'hb, MS_WHICH = 4'hc,
    MS_LOCK = 4'hd, MS_HOLD = 4'he, MS_LDCMP = 4'hf
  } pfs_mon_sel_t;

  typedef struct packed {
    logic diff_mode;
    logic ref_sel;
    logic sel_ok;
    logic unsel_ok;
    logic first_frq_ok;
    logic second_frq_ok;
    logic vco_ok;
    logic digital_lock_flag;
    logic holdover;
    logic lock_cmp;
  } pfs_mon_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } pfs_apb_req_t;

endpackage

// ==== rtl/pfs_sync.sv ====
// Purpose: Three-stage synchroniser for pin inputs
// Assumes: Pins are asynchronous to sys_clk_i
// Notes:   Output follows once stages two and three agree
`timescale 1ns/1ps
module pfs_sync #(
  parameter int W = 3
) (
  input  wire logic         sys_clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] lvl_o
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] lvl_q;

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
        s1_q[i]  <= 1'b0;
        s2_q[i]  <= 1'b0;
        s3_q[i]  <= 1'b0;
        lvl_q[i] <= 1'b0;
      end else begin
        s1_q[i] <= pin_i[i];
        s2_q[i] <= s1_q[i];
        s3_q[i] <= s2_q[i];
        // Filters a single-stage glitch
        if (s2_q[i] == s3_q[i]) begin
          lvl_q[i] <= s3_q[i];
        end
      end
    end
  end

  assign lvl_o = lvl_q;
endmodule

// ==== rtl/pfs_div.sv ====
// Purpose: Programmable event divider
// Assumes: Divide value of zero behaves as one
// Notes:   wrap_o is combinational, pulse_o one cycle later
`timescale 1ns/1ps
module pfs_div
  import pfs_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  input  wire logic        clr_i,
  input  wire logic        tick_i,
  input  wire logic [13:0] div_i,
  output logic             wrap_o,
  output logic             pulse_o
);
  logic [13:0] cnt_q;
  logic        pulse_q;
  wire         last = (div_i <= PFS_DIV_ONE) ||
                      (cnt_q >= div_i - PFS_DIV_ONE);

  assign wrap_o  = tick_i & last & ~clr_i;
  assign pulse_o = pulse_q;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i || clr_i) begin
      cnt_q   <= '0;
      pulse_q <= 1'b0;
    end else begin
      pulse_q <= wrap_o;
      if (tick_i) begin
        cnt_q <= last ? '0 : cnt_q + PFS_DIV_ONE;
      end
    end
  end
endmodule

// ==== testbench/pfs_top_bench.sv ====
// Purpose: Self-checking bench for the divider and status selector
// Assumes: Zero wait state APB, byte address is index times four
// Notes:   Pins toggle every five cycles, far slower than the sync
`timescale 1ns/1ps
module pfs_top_bench
  import pfs_pkg::*;
;
  logic         sys_clk_i;
  logic         rst_i;
  pfs_apb_req_t req;
  logic         pready_o;
  logic [31:0]  prdata_o;
  logic         pslverr_o;
  logic [1:0]   ref_pin_i = 2'b00;
  logic         vco_pin_i = 1'b0;
  pfs_mon_t     mon;
  logic         status_o;
  logic         fbk_div_o;
  logic         ref_div_o;
  logic         pump_up_o;
  logic         pump_dn_o;
  logic [2:0]   mask;
  int           tick = 0;
  int           vco_cnt = 0;
  int           last_st = 0;
  int           prev_st = 0;
  int           n_fbk = 0;
  int           n_ref = 0;
  int           hi_cnt = 0;
  int           err_count;
  int           n_compared;

  pfs_top dut (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .apb_i     (req),
    .pready_o  (pready_o),
    .prdata_o  (prdata_o),
    .pslverr_o (pslverr_o),
    .ref_pin_i (ref_pin_i),
    .vco_pin_i (vco_pin_i),
    .mon_i     (mon),
    .status_o  (status_o),
    .fbk_div_o (fbk_div_o),
    .ref_div_o (ref_div_o),
    .pump_up_o (pump_up_o),
    .pump_dn_o (pump_dn_o)
  );

  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end

  // Pins outside the mask return low so a stopped source reads quiet
  always @(posedge sys_clk_i) begin
    tick <= (tick == 4) ? 0 : tick + 1;
    if (tick == 4) begin
      ref_pin_i <= (ref_pin_i ^ mask[1:0]) & mask[1:0];
      vco_pin_i <= (vco_pin_i ^ mask[2]) & mask[2];
      if (mask[2] && !vco_pin_i) vco_cnt <= vco_cnt + 1;
    end
    if (fbk_div_o === 1'b1) begin
      prev_st <= last_st;
      last_st <= vco_cnt;
      n_fbk   <= n_fbk + 1;
    end
    if (ref_div_o === 1'b1) n_ref <= n_ref + 1;
    if (status_o === 1'b1) hi_cnt <= hi_cnt + 1;
  end

  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask

  // Waits on pready, never on a fixed count
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic er);
    @(posedge sys_clk_i);
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite  <= wr;
    req.paddr   <= a;
    req.pwdata  <= wd;
    @(posedge sys_clk_i);
    req.penable <= 1'b1;
    @(posedge sys_clk_i);
    while (pready_o !== 1'b1) begin
      @(posedge sys_clk_i);
    end
    rd = prdata_o;
    er = pslverr_o;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(nm, x, r);
    chk_bit(nm, xe, e);
  endtask

  task automatic t_regs;
    logic [7:0]  ad [5] = '{8'h1c, 8'h58, 8'h44, 8'h4c, 8'h50};
    logic [31:0] rv [5] = '{0, 0, 1, 0, 1};
    logic [31:0] mk [5] = '{32'hff, 32'hff, 32'h3fff, 32'h3f, 32'h1fff};
    chk_bit("status after reset", 1'b0, status_o);
    for (int i = 0; i < 5; i++) begin
      rdc("reset value", ad[i], rv[i], 1'b0);
      wr(ad[i], 32'hffff_ffff);
      rdc("upper bits", ad[i], mk[i], 1'b0);
      wr(ad[i], rv[i]);
    end
    rdc("unmapped", 8'h20, 32'h0, 1'b1);
    rdc("misaligned", 8'h1d, 32'h0, 1'b1);
    wr(8'h7c, 32'hff);
    $display("test regs done");
  endtask

  function automatic logic lvl_exp(input logic [5:0] c, input pfs_mon_t m);
    logic v;
    case (c[3:0])
      4'h5:    v = m.sel_ok;
      4'h6:    v = m.unsel_ok & ~m.diff_mode;
      4'h7:    v = m.first_frq_ok;
      4'h8:    v = m.second_frq_ok;
      4'h9:    v = m.first_frq_ok & m.second_frq_ok;
      4'ha:    v = m.digital_lock_flag & m.sel_ok & m.vco_ok;
      4'hb:    v = m.vco_ok;
      // Differential input always counts as the first reference
      4'hc:    v = m.ref_sel & ~m.diff_mode;
      4'hd:    v = m.digital_lock_flag;
      4'he:    v = m.holdover;
      4'hf:    v = m.lock_cmp;
      default: v = 1'b0;
    endcase
    return c[5] ? (v ^ c[4]) : 1'b0;
  endfunction

  // Clock and pulse codes are skipped; the dynamic test covers all but 000011 and 110010-110100
  task automatic t_levels;
    pfs_mon_t pat [3] = '{10'b0011111111, 10'b0101010101, 10'b1111010110};
    logic [5:0] c;
    mask <= 3'b000;
    for (int p = 0; p < 3; p++) begin
      mon <= pat[p];
      for (int i = 0; i < 64; i++) begin
        c = 6'(i);
        if (c[5] ? (c[3:0] inside {[1:4]}) : (c inside {[1:6]})) continue;
        wr(8'h1c, {24'h0, c, 2'b00});
        repeat (3) @(posedge sys_clk_i);
        chk_bit("status level", lvl_exp(c, mon), status_o);
      end
    end
    $display("test levels done");
  endtask

  task automatic dyn(input logic [5:0] c, input logic [2:0] m,
                     input logic df, input logic on);
    int s;
    mon      <= {df, 9'h000};
    mask     <= m;
    wr(8'h1c, {24'h0, c, 2'b00});
    repeat (30) @(posedge sys_clk_i);
    s = hi_cnt;
    repeat (200) @(posedge sys_clk_i);
    chk_bit("status activity", on, hi_cnt != s);
  endtask

  task automatic t_dynamic;
    wr(8'h50, 32'h3);
    wr(8'h58, {29'h0, PRE_DIV2});
    dyn(6'h01, 3'b100, 1'b0, 1'b1);
    dyn(6'h00, 3'b111, 1'b0, 1'b0);
    dyn(6'h02, 3'b001, 1'b0, 1'b1);
    dyn(6'h04, 3'b100, 1'b0, 1'b1);
    dyn(6'h05, 3'b001, 1'b0, 1'b1);
    // Only reference edges: up latches, a late down was cleared
    chk_bit("pump up", 1'b1, pump_up_o);
    chk_bit("pump down", 1'b0, pump_dn_o);
    dyn(6'h06, 3'b100, 1'b0, 1'b1);
    chk_bit("pump up", 1'b0, pump_up_o);
    chk_bit("pump down", 1'b1, pump_dn_o);
    dyn(6'h21, 3'b001, 1'b0, 1'b1);
    dyn(6'h21, 3'b110, 1'b0, 1'b0);
    dyn(6'h22, 3'b010, 1'b0, 1'b1);
    dyn(6'h22, 3'b010, 1'b1, 1'b0);
    dyn(6'h23, 3'b001, 1'b0, 1'b1);
    dyn(6'h23, 3'b010, 1'b0, 1'b0);
    dyn(6'h24, 3'b010, 1'b0, 1'b1);
    dyn(6'h24, 3'b010, 1'b1, 1'b0);
    dyn(6'h31, 3'b001, 1'b0, 1'b1);
    $display("test dynamic done");
  endtask

  // Third pulse spacing avoids the partial period after reprogramming
  task automatic div(input pfs_pre_t p, input logic byp, input int a,
                     input int b, input int n);
    int s;
    wr(8'h4c, a);
    wr(8'h50, b);
    wr(8'h58, {28'h0, byp, p});
    mask <= 3'b100;
    s = n_fbk;
    while (n_fbk < s + 3) begin
      @(posedge sys_clk_i);
    end
    chk("feedback divide", n, last_st - prev_st);
  endtask

  task automatic t_divider;
    div(PRE_DIV1, 1'b0, 0, 5, 5);
    div(PRE_DIV2, 1'b0, 0, 3, 6);
    div(PRE_DIV3, 1'b0, 0, 4, 12);
    div(PRE_DM2, 1'b0, 1, 3, 7);
    div(PRE_DM4, 1'b0, 0, 3, 12);
    div(PRE_DM8, 1'b0, 2, 3, 26);
    div(PRE_DM16, 1'b0, 1, 2, 33);
    div(PRE_DM32, 1'b0, 0, 2, 64);
    div(PRE_DM32, 1'b0, 1, 2, 65);
    div(PRE_DIV2, 1'b1, 0, 5, 2);
    div(PRE_DM4, 1'b1, 1, 2, 9);
    $display("test divider done");
  endtask

  task automatic rst_case(input logic [2:0] bits, input logic f_on,
                          input logic r_on);
    int sf;
    int sr;
    wr(8'h58, {25'h0, bits, 1'b0, PRE_DIV2});
    repeat (30) @(posedge sys_clk_i);
    sf = n_fbk;
    sr = n_ref;
    repeat (300) @(posedge sys_clk_i);
    chk_bit("feedback runs", f_on, n_fbk != sf);
    chk_bit("reference runs", r_on, n_ref != sr);
  endtask

  task automatic t_resets;
    wr(8'h4c, 32'h0);
    wr(8'h50, 32'h3);
    mask <= 3'b101;
    rst_case(3'b001, 1'b0, 1'b0);
    rst_case(3'b000, 1'b1, 1'b1);
    rst_case(3'b010, 1'b0, 1'b1);
    rst_case(3'b100, 1'b1, 1'b0);
    $display("test resets done");
  endtask

  initial begin
    rst_i = 1'b1;
    req = '0;
    mon = '0;
    mask = 3'b000;
    err_count = 0;
    n_compared = 0;
    repeat (4) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_levels();
    t_dynamic();
    t_divider();
    t_resets();
    end_of_test();
  end

  // Whole run needs about 12k cycles
  initial begin
    repeat (90000) @(posedge sys_clk_i);
    err_count++;
    end_of_test();
  end
endmodule
